// >>> verilog/ocs_event_logic.sv
// Overcurrent sense sampler, debouncer, event flags and interrupt
`timescale 1ns/1ps

// Overview of operation
// - First debounced result after enable sets valid
// - Debounced match toggle sets change flag
// - Writing one clears a flag
// - Valid enable routes valid flag to interrupt
// - Match enable routes change flag to interrupt
// - Threshold takes effect on upper byte
// - Debounce period in 100 us units
// - Two-bit mode selects channels or off
// - Sample every 100 us, alternating halves
// - Unsampled channel match held cleared
module ocs_event_logic (
    input wire logic clock,
    input wire logic rst_n,
    input wire ocs_pkg::ocs_wr_s reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rd_addr,
    output logic [7:0] reg_rdata_ff,
    input wire logic sense_input_one,
    input wire logic sense_input_two,
    output ocs_pkg::ocs_mode_e comparator_mode_ff,
    output logic sample_select_ff,
    output ocs_pkg::ocs_thr_s threshold_ff,
    output logic overcurrent_interrupt_ff
);
    import ocs_pkg::*;

    // Channel c is sampled in this mode
    function automatic logic chan_on(input ocs_mode_e m, input int c);
        chan_on = (c == 0) ? m[0] : m[1];
    endfunction : chan_on

    // ==================================================
    // Input synchronisers
    logic [1:0] sync1_ff;
    logic [1:0] sync2_ff;

    // Comparator outputs are asynchronous to the core clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 2'b00;
            sync2_ff <= 2'b00;
        end else begin
            sync1_ff <= {sense_input_two, sense_input_one};
            sync2_ff <= sync1_ff;
        end
    end

    // ==================================================
    // Registers
    logic [3:0] flags_ff;        // {vld2, vld1, chg2, chg1}
    logic [3:0] nxt_flags;
    logic [3:0] irq_en_ff;
    logic [3:0] nxt_irq_en;
    logic [7:0] period_ff;
    logic [7:0] nxt_period;
    logic [7:0] thr_lo1_ff;
    logic [7:0] nxt_thr_lo1;
    logic [7:0] thr_lo2_ff;
    logic [7:0] nxt_thr_lo2;
    ocs_mode_e nxt_mode;
    ocs_thr_s nxt_threshold;
    logic [7:0] nxt_rdata;
    logic nxt_irq;
    logic [1:0] match_bits;
    logic [1:0] dec_valid;
    logic [1:0] dec_change;
    logic [3:0] clr_mask;

    // Register writes, flag updates and read data
    always_comb begin
        nxt_mode = comparator_mode_ff;
        nxt_irq_en = irq_en_ff;
        nxt_period = period_ff;
        nxt_thr_lo1 = thr_lo1_ff;
        nxt_thr_lo2 = thr_lo2_ff;
        nxt_threshold = threshold_ff;
        clr_mask = 4'h0;
        if (reg_wr.wr) begin
            unique case (reg_wr.addr)
                OCS_ADDR_MODE: nxt_mode = ocs_mode_e'(reg_wr.data[1:0]);
                OCS_ADDR_STATUS: begin
                    clr_mask = {reg_wr.data[OCS_BIT_VALID_LO +: 2],
                        reg_wr.data[OCS_BIT_CHANGE_LO +: 2]};
                end
                OCS_ADDR_ENABLE: begin
                    nxt_irq_en = {reg_wr.data[OCS_BIT_VALID_LO +: 2],
                        reg_wr.data[OCS_BIT_CHANGE_LO +: 2]};
                end
                // Low byte parks until the upper byte arrives, so the DAC never
                // sees a half-written code
                OCS_ADDR_THR1_LO: nxt_thr_lo1 = reg_wr.data;
                OCS_ADDR_THR1_HI: nxt_threshold.one = {reg_wr.data[1:0], thr_lo1_ff};
                OCS_ADDR_THR2_LO: nxt_thr_lo2 = reg_wr.data;
                OCS_ADDR_THR2_HI: nxt_threshold.two = {reg_wr.data[1:0], thr_lo2_ff};
                OCS_ADDR_DEBOUNCE: nxt_period = reg_wr.data;
                default: ;
            endcase
        end
        // Hardware set wins over a clear in the same cycle
        nxt_flags = (flags_ff & ~clr_mask) | {dec_valid, dec_change};
        nxt_irq = |(flags_ff & irq_en_ff);
        nxt_rdata = reg_rdata_ff;
        if (reg_rd) begin
            unique case (reg_rd_addr)
                OCS_ADDR_MODE: nxt_rdata = {comparator_mode_ff != OCS_MODE_OFF, 5'h00,
                    comparator_mode_ff};
                OCS_ADDR_MATCH: nxt_rdata = {6'h00, match_bits};
                OCS_ADDR_STATUS: nxt_rdata = {flags_ff[3:2], 4'h0, flags_ff[1:0]};
                OCS_ADDR_ENABLE: nxt_rdata = {irq_en_ff[3:2], 4'h0, irq_en_ff[1:0]};
                OCS_ADDR_THR1_LO: nxt_rdata = threshold_ff.one[7:0];
                OCS_ADDR_THR1_HI: nxt_rdata = {6'h00, threshold_ff.one[9:8]};
                OCS_ADDR_THR2_LO: nxt_rdata = threshold_ff.two[7:0];
                OCS_ADDR_THR2_HI: nxt_rdata = {6'h00, threshold_ff.two[9:8]};
                OCS_ADDR_DEBOUNCE: nxt_rdata = period_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            comparator_mode_ff <= OCS_MODE_OFF;
            irq_en_ff <= 4'h0;
            period_ff <= OCS_RST_DEBOUNCE;
            thr_lo1_ff <= 8'h00;
            thr_lo2_ff <= 8'h00;
            threshold_ff <= {OCS_RST_THRESHOLD, OCS_RST_THRESHOLD};
            flags_ff <= 4'h0;
            overcurrent_interrupt_ff <= 1'b0;
            reg_rdata_ff <= 8'h00;
        end else begin
            comparator_mode_ff <= nxt_mode;
            irq_en_ff <= nxt_irq_en;
            period_ff <= nxt_period;
            thr_lo1_ff <= nxt_thr_lo1;
            thr_lo2_ff <= nxt_thr_lo2;
            threshold_ff <= nxt_threshold;
            flags_ff <= nxt_flags;
            overcurrent_interrupt_ff <= nxt_irq;
            reg_rdata_ff <= nxt_rdata;
        end
    end

    // ==================================================
    // Sample slot timer and channel selection
    logic [11:0] slot_cnt_ff;
    logic [11:0] nxt_slot_cnt;
    logic nxt_sample_select;
    logic slot_tick;

    // Timer idles while powered down so a fresh enable starts a full slot
    always_comb begin
        slot_tick = (comparator_mode_ff != OCS_MODE_OFF) && (slot_cnt_ff == OCS_SLOT_LAST);
        nxt_slot_cnt = 12'h000;
        if (comparator_mode_ff != OCS_MODE_OFF && !slot_tick) begin
            nxt_slot_cnt = 12'(slot_cnt_ff + 12'h001);
        end
        unique case (comparator_mode_ff)
            OCS_MODE_OFF: nxt_sample_select = 1'b0;
            OCS_MODE_ONE: nxt_sample_select = 1'b0;
            OCS_MODE_TWO: nxt_sample_select = 1'b1;
            OCS_MODE_BOTH: nxt_sample_select = slot_tick ? ~sample_select_ff
                : sample_select_ff;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slot_cnt_ff <= 12'h000;
            sample_select_ff <= 1'b0;
        end else begin
            slot_cnt_ff <= nxt_slot_cnt;
            sample_select_ff <= nxt_sample_select;
        end
    end

    // ==================================================
    // Per-channel debouncer
    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic cand_ff;
        logic nxt_cand;
        logic match_ff;
        logic nxt_match;
        logic settled_ff;
        logic nxt_settled;
        logic [7:0] cnt_ff;
        logic [7:0] nxt_cnt;
        logic seen_ff;
        logic nxt_seen;
        logic own_slot;
        logic dv;
        logic dc;

        // Candidate must hold for the whole period before it becomes the match
        always_comb begin
            own_slot = (sample_select_ff == 1'(c));
            nxt_cand = cand_ff;
            nxt_match = match_ff;
            nxt_settled = settled_ff;
            nxt_cnt = cnt_ff;
            nxt_seen = seen_ff;
            dv = 1'b0;
            dc = 1'b0;
            if (!chan_on(comparator_mode_ff, c)) begin
                nxt_cand = 1'b0;
                nxt_match = 1'b0;
                nxt_settled = 1'b0;
                nxt_cnt = 8'h00;
                nxt_seen = 1'b0;
            end else if (slot_tick) begin
                // A channel never looked at yet has no result to report
                nxt_seen = seen_ff | own_slot;
                if (own_slot && sync2_ff[c] != cand_ff) begin
                    nxt_cand = sync2_ff[c];
                    nxt_cnt = 8'h00;
                end else if ((seen_ff || own_slot) && cnt_ff >= period_ff) begin
                    nxt_match = cand_ff;
                    nxt_cnt = 8'h00;
                    dc = cand_ff != match_ff;
                    dv = !settled_ff;
                    nxt_settled = 1'b1;
                end else begin
                    nxt_cnt = 8'(cnt_ff + 8'h01);
                end
            end
        end

        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                cand_ff <= 1'b0;
                match_ff <= 1'b0;
                settled_ff <= 1'b0;
                cnt_ff <= 8'h00;
                seen_ff <= 1'b0;
            end else begin
                cand_ff <= nxt_cand;
                match_ff <= nxt_match;
                settled_ff <= nxt_settled;
                cnt_ff <= nxt_cnt;
                seen_ff <= nxt_seen;
            end
        end

        assign match_bits[c] = match_ff;
        assign dec_valid[c] = dv;
        assign dec_change[c] = dc;

        // ==================================================
        // Channel checks
        a_match_off_clear: assert property (@(posedge clock) disable iff (!rst_n)
            !chan_on(comparator_mode_ff, c) |=> !match_ff)
            else $error("match bit not cleared for idle channel");
        a_change_on_toggle: assert property (@(posedge clock) disable iff (!rst_n)
            $changed(match_ff) && $past(chan_on(comparator_mode_ff, c)) && match_ff
            |-> flags_ff[c])
            else $error("change flag missing after match toggle");
        a_valid_first: assert property (@(posedge clock) disable iff (!rst_n)
            $rose(settled_ff) |-> flags_ff[2 + c])
            else $error("valid flag missing after first decision");
    end

    // ==================================================
    // Block checks
    a_irq_follows_flags: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 overcurrent_interrupt_ff == |($past(flags_ff) & $past(irq_en_ff)))
        else $error("interrupt does not follow enabled flags");
    a_w1c_clears: assert property (@(posedge clock) disable iff (!rst_n)
        reg_wr.wr && reg_wr.addr == OCS_ADDR_STATUS && reg_wr.data[0] && !dec_change[0]
        |=> !flags_ff[0])
        else $error("write one did not clear change flag");
    a_set_beats_clear: assert property (@(posedge clock) disable iff (!rst_n)
        dec_valid[0] |=> flags_ff[2])
        else $error("set lost against clear");
    a_thr_lo_holds: assert property (@(posedge clock) disable iff (!rst_n)
        reg_wr.wr && reg_wr.addr == OCS_ADDR_THR1_LO |=> $stable(threshold_ff.one))
        else $error("threshold changed on low byte");
    a_thr_hi_commits: assert property (@(posedge clock) disable iff (!rst_n)
        reg_wr.wr && reg_wr.addr == OCS_ADDR_THR1_HI
        |=> threshold_ff.one == {$past(reg_wr.data[1:0]), $past(thr_lo1_ff)})
        else $error("threshold not committed on upper byte");
    a_slot_spacing: assert property (@(posedge clock) disable iff (!rst_n)
        slot_tick && comparator_mode_ff == OCS_MODE_BOTH
        |=> (sample_select_ff != $past(sample_select_ff)) ##0 (!slot_tick [*8]))
        else $error("slot timing or alternation wrong");

endmodule : ocs_event_logic

// >>> verilog/ocs_pkg.sv
// Package with register map, field layout, modes and timing for overcurrent event logic
package ocs_pkg;

    // ==================================================
    // Register byte addresses
    localparam logic [7:0] OCS_ADDR_MODE = 8'h80;
    localparam logic [7:0] OCS_ADDR_MATCH = 8'h81;
    localparam logic [7:0] OCS_ADDR_STATUS = 8'h82;
    localparam logic [7:0] OCS_ADDR_ENABLE = 8'h83;
    localparam logic [7:0] OCS_ADDR_THR1_LO = 8'h84;
    localparam logic [7:0] OCS_ADDR_THR1_HI = 8'h85;
    localparam logic [7:0] OCS_ADDR_THR2_LO = 8'h86;
    localparam logic [7:0] OCS_ADDR_THR2_HI = 8'h87;
    localparam logic [7:0] OCS_ADDR_DEBOUNCE = 8'h88;

    // ==================================================
    // Field positions inside the status, enable and mode registers
    localparam int OCS_BIT_VALID_LO = 6;
    localparam int OCS_BIT_CHANGE_LO = 0;
    localparam int OCS_BIT_ACTIVE = 7;

    // ==================================================
    // Reset values
    localparam logic [7:0] OCS_RST_DEBOUNCE = 8'h0f;
    localparam logic [9:0] OCS_RST_THRESHOLD = 10'h000;

    // ==================================================
    // Timing: one comparator sample slot per 100 us
    localparam int OCS_CLK_HZ = 40000000;
    localparam int OCS_SLOT_US = 100;
    localparam int OCS_SLOT_CYCLES = (OCS_CLK_HZ / 1000000) * OCS_SLOT_US;
    localparam logic [11:0] OCS_SLOT_LAST = 12'(OCS_SLOT_CYCLES - 1);

    // ==================================================
    // Comparator control modes
    typedef enum logic [1:0] {
        OCS_MODE_OFF = 2'b00,
        OCS_MODE_ONE = 2'b01,
        OCS_MODE_TWO = 2'b10,
        OCS_MODE_BOTH = 2'b11
    } ocs_mode_e;

    // Register write request, one byte
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } ocs_wr_s;

    // Effective thresholds driven to the DACs
    typedef struct packed {
        logic [9:0] one;
        logic [9:0] two;
    } ocs_thr_s;

endpackage : ocs_pkg

// >>> testbench/ocs_sense_model.sv
// Behavioural model of the two overcurrent comparator outputs
`timescale 1ns/1ps

// ==================================================
// Comparator outputs
module ocs_sense_model (
    input wire logic clock,
    input wire logic [1:0] level,
    output logic sense_input_one,
    output logic sense_input_two
);
    // Outputs move away from the clock edge, as an unclocked comparator would
    initial begin
        sense_input_one = 1'b0;
        sense_input_two = 1'b0;
    end
    always @(posedge clock) begin
        sense_input_one <= #7 level[0];
        sense_input_two <= #7 level[1];
    end
endmodule : ocs_sense_model

// >>> testbench/tb_top.sv
// Self-checking bench for the overcurrent event logic
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_top;
    import ocs_pkg::*;
    localparam int SLOT = OCS_SLOT_CYCLES;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    ocs_wr_s reg_wr = '0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rd_addr = 8'h00;
    logic [7:0] reg_rdata_ff;
    logic [1:0] level = 2'b00;
    logic sense_input_one;
    logic sense_input_two;
    ocs_mode_e comparator_mode_ff;
    logic sample_select_ff;
    ocs_thr_s threshold_ff;
    logic overcurrent_interrupt_ff;
    int n_mismatch = 0;
    int check_count = 0;
    int seed = 66286;
    logic [7:0] rd, lo, hi;
    logic [9:0] p1 = 10'h000;
    logic [9:0] p2 = 10'h000;

    // ==================================================
    // Clock, design and comparator model
    always #12.5 clock = ~clock;
    ocs_event_logic DUT (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rd_addr(reg_rd_addr), .reg_rdata_ff(reg_rdata_ff),
        .sense_input_one(sense_input_one), .sense_input_two(sense_input_two),
        .comparator_mode_ff(comparator_mode_ff), .sample_select_ff(sample_select_ff),
        .threshold_ff(threshold_ff), .overcurrent_interrupt_ff(overcurrent_interrupt_ff));
    ocs_sense_model MODEL (.clock(clock), .level(level),
        .sense_input_one(sense_input_one), .sense_input_two(sense_input_two));

    // ==================================================
    // Bus tasks and expectations
    function automatic logic [9:0] exp_thr(input logic [7:0] l, input logic [7:0] h);
        return {h[1:0], l}; // Upper byte carries only bits 9:8
    endfunction : exp_thr
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock); #1;
        reg_wr = '{wr: 1'b1, addr: a, data: d};
        @(posedge clock); #1;
        reg_wr.wr = 1'b0;
    endtask : wr_reg
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock); #1;
        reg_rd = 1'b1;
        reg_rd_addr = a;
        @(posedge clock); #1;
        reg_rd = 1'b0;
        @(posedge clock); #1;
        rd = reg_rdata_ff;
        `CHK(rd, e)
    endtask : chk_reg
    // Bounded wait; a hang shows as a mismatch, not a stall
    task automatic wait_irq(input logic lvl, input int n);
        for (int i = 0; i < n && overcurrent_interrupt_ff !== lvl; i++) begin
            @(posedge clock);
            #1;
        end
        `CHK(overcurrent_interrupt_ff, lvl)
    endtask : wait_irq
    task automatic test_done();
        $display("mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    // Watchdog sized to about fifteen sample slots plus margin
    initial begin
        repeat (24 * SLOT) @(posedge clock);
        n_mismatch++;
        test_done();
    end

    // ==================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clock);
        #1 rst_n = 1'b1;
        chk_reg(OCS_ADDR_MODE, 8'h00);
        chk_reg(OCS_ADDR_STATUS, 8'h00);
        chk_reg(OCS_ADDR_THR1_HI, 8'h00);
        chk_reg(OCS_ADDR_DEBOUNCE, OCS_RST_DEBOUNCE);
        chk_reg(8'h90, 8'h00);
        // Random thresholds while off; low byte alone must not show
        for (int i = 0; i < 3; i++) begin
            lo = 8'($random(seed));
            hi = 8'($random(seed));
            wr_reg(OCS_ADDR_THR1_LO, lo);
            `CHK(threshold_ff.one, p1)
            wr_reg(OCS_ADDR_THR1_HI, hi);
            p1 = exp_thr(lo, hi);
            `CHK(threshold_ff.one, p1)
            wr_reg(OCS_ADDR_THR2_LO, hi);
            `CHK(threshold_ff.two, p2)
            wr_reg(OCS_ADDR_THR2_HI, lo);
            p2 = exp_thr(hi, lo);
            `CHK(threshold_ff.two, p2)
        end
        chk_reg(OCS_ADDR_THR2_LO, p2[7:0]);
        chk_reg(OCS_ADDR_THR1_HI, {6'h00, p1[9:8]});
        wr_reg(OCS_ADDR_DEBOUNCE, 8'h00);
        chk_reg(OCS_ADDR_DEBOUNCE, 8'h00);
        wr_reg(OCS_ADDR_ENABLE, 8'hff);
        chk_reg(OCS_ADDR_ENABLE, 8'hc3);
        // Channel one rises, then falls
        level = 2'b01;
        wr_reg(OCS_ADDR_MODE, 8'h01);
        chk_reg(OCS_ADDR_MODE, 8'h81);
        `CHK(comparator_mode_ff, OCS_MODE_ONE)
        `CHK(sample_select_ff, 1'b0)
        wait_irq(1'b1, 3 * SLOT);
        chk_reg(OCS_ADDR_STATUS, 8'h41);
        chk_reg(OCS_ADDR_MATCH, 8'h01);
        wr_reg(OCS_ADDR_STATUS, 8'h01);
        chk_reg(OCS_ADDR_STATUS, 8'h40);
        `CHK(overcurrent_interrupt_ff, 1'b1)
        wr_reg(OCS_ADDR_STATUS, 8'h40);
        wait_irq(1'b0, 4);
        level = 2'b00;
        wait_irq(1'b1, 3 * SLOT);
        chk_reg(OCS_ADDR_STATUS, 8'h01);
        chk_reg(OCS_ADDR_MATCH, 8'h00);
        // Masked change flag stays quiet until enabled
        wr_reg(OCS_ADDR_ENABLE, 8'h00);
        wr_reg(OCS_ADDR_STATUS, 8'h01);
        level = 2'b01;
        repeat (3 * SLOT) @(posedge clock);
        chk_reg(OCS_ADDR_STATUS, 8'h01);
        `CHK(overcurrent_interrupt_ff, 1'b0)
        wr_reg(OCS_ADDR_ENABLE, 8'h01);
        wait_irq(1'b1, 4);
        wr_reg(OCS_ADDR_STATUS, 8'hff);
        wait_irq(1'b0, 4);
        // Off clears matches; both channels alternate
        wr_reg(OCS_ADDR_MODE, 8'h00);
        chk_reg(OCS_ADDR_MATCH, 8'h00);
        wr_reg(OCS_ADDR_STATUS, 8'hff);
        wr_reg(OCS_ADDR_ENABLE, 8'h80);
        level = 2'b11;
        wr_reg(OCS_ADDR_MODE, 8'h03);
        wait_irq(1'b1, 6 * SLOT);
        `CHK(sample_select_ff, 1'b1)
        chk_reg(OCS_ADDR_MATCH, 8'h03);
        chk_reg(OCS_ADDR_STATUS, 8'hc3);
        wr_reg(OCS_ADDR_MODE, 8'h02);
        chk_reg(OCS_ADDR_MATCH, 8'h02);
        `CHK(sample_select_ff, 1'b1)
        `CHK(rd[0], 1'b0)
        // Longer debounce period delays the decision
        wr_reg(OCS_ADDR_MODE, 8'h00);
        wr_reg(OCS_ADDR_STATUS, 8'hff);
        wr_reg(OCS_ADDR_DEBOUNCE, 8'h03);
        wr_reg(OCS_ADDR_ENABLE, 8'h01);
        level = 2'b01;
        wr_reg(OCS_ADDR_MODE, 8'h01);
        repeat (2 * SLOT + 100) @(posedge clock);
        `CHK(overcurrent_interrupt_ff, 1'b0)
        wait_irq(1'b1, 5 * SLOT);
        test_done();
    end
endmodule : tb_top
